//--- hw/frs_top.sv
// Fault reaction selector: reaction code objects, hardware info objects and event decode.
// Assumes events, positions and the object request come from logic on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module frs_top
  import frs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire frs_od_req_type od_req_i,
  input wire logic deviation_event_i,
  input wire logic limit_event_i,
  input wire logic [31:0] limit_pos_i,
  input wire logic warn_clear_i,
  input wire logic [31:0] eeprom_size_i,
  input wire frs_env_type env_i,
  output logic od_ack_o,
  output logic od_err_o,
  output logic [31:0] od_rdata_o,
  output logic react_valid_o,
  output frs_action_type react_o,
  output logic [15:0] drive_status_word_o,
  output logic [31:0] limit_pos_o,
  output logic limit_pos_valid_o
);

  // Code validity checks, used on write only
  function automatic logic dev_code_ok(input logic [15:0] c);
    dev_code_ok = (c == CODE_NONE) || (c == CODE_OFF) || (c == CODE_SLOW) || (c == CODE_QUICK);
  endfunction

  function automatic logic lim_code_ok(input logic [15:0] c);
    lim_code_ok = (c == CODE_DISCARD) || (c == CODE_NONE) || (c == CODE_OFF) || (c == CODE_SLOW)
      || (c == CODE_QUICK) || (c == CODE_SLOW_QS) || (c == CODE_QUICK_QS);
  endfunction

  // Code to action; limit codes also name the state after the stop
  function automatic frs_action_type decode_action(input logic [15:0] c, input logic is_limit);
    frs_action_type a;
    a = '0;
    case (c)
      CODE_OFF: begin
        a.driver_off = 1'b1;
        a.to_switch_on_disabled = is_limit;
      end
      CODE_SLOW: begin
        a.brake_slow = 1'b1;
        a.to_switch_on_disabled = is_limit;
      end
      CODE_QUICK: begin
        a.brake_quick = 1'b1;
        a.to_switch_on_disabled = is_limit;
      end
      CODE_SLOW_QS: begin
        a.brake_slow = is_limit;
        a.to_quick_stop_active = is_limit;
        a.keep_energized = is_limit;
      end
      CODE_QUICK_QS: begin
        a.brake_quick = is_limit;
        a.to_quick_stop_active = is_limit;
        a.keep_energized = is_limit;
      end
      default: begin
        a = '0;
      end
    endcase
    decode_action = a;
  endfunction

  // Object dictionary state
  logic [15:0] dev_code_r;
  logic [15:0] dev_code_nxt;
  logic [15:0] lim_code_r;
  logic [15:0] lim_code_nxt;
  logic [31:0] hw_cfg_r;
  logic [31:0] hw_cfg_nxt;
  logic od_ack_r;
  logic od_ack_nxt;
  logic od_err_r;
  logic od_err_nxt;
  logic [31:0] od_rdata_r;
  logic [31:0] od_rdata_nxt;

  // Reaction state
  logic react_valid_r;
  logic react_valid_nxt;
  frs_action_type react_r;
  frs_action_type react_nxt;
  logic warn_r;
  logic warn_nxt;
  logic [31:0] lim_pos_r;
  logic [31:0] lim_pos_nxt;
  logic lim_pos_valid_r;
  logic lim_pos_valid_nxt;

  logic [31:0] env_word [OP_COND_N];

  // Environment entries in subindex order
  assign env_word[0] = env_i.volt_power_mv;
  assign env_word[1] = env_i.volt_logic_mv;
  assign env_word[2] = env_i.temp_pcb_dc;
  assign env_word[3] = env_i.temp_motor_dc;
  assign env_word[4] = env_i.temp_chip_dc;

  // Object access: one request answered in the next cycle
  always_comb begin
    dev_code_nxt = dev_code_r;
    lim_code_nxt = lim_code_r;
    hw_cfg_nxt = hw_cfg_r;
    od_ack_nxt = 1'b0;
    od_err_nxt = 1'b0;
    od_rdata_nxt = od_rdata_r;
    if (od_req_i.req) begin
      od_ack_nxt = 1'b1;
      od_err_nxt = 1'b1;
      case (od_req_i.index)
        OBJ_DEV_CODE: begin
          if (od_req_i.sub == SUB_ZERO) begin
            if (od_req_i.write) begin
              if (dev_code_ok(od_req_i.wdata[15:0])) begin
                dev_code_nxt = od_req_i.wdata[15:0];
                od_err_nxt = 1'b0;
              end
            end else begin
              od_rdata_nxt = {{16{dev_code_r[15]}}, dev_code_r};
              od_err_nxt = 1'b0;
            end
          end
        end
        OBJ_LIM_CODE: begin
          if (od_req_i.sub == SUB_ZERO) begin
            if (od_req_i.write) begin
              if (lim_code_ok(od_req_i.wdata[15:0])) begin
                lim_code_nxt = od_req_i.wdata[15:0];
                od_err_nxt = 1'b0;
              end
            end else begin
              od_rdata_nxt = {{16{lim_code_r[15]}}, lim_code_r};
              od_err_nxt = 1'b0;
            end
          end
        end
        OBJ_HW_INFO: begin
          if (!od_req_i.write && od_req_i.sub == SUB_ZERO) begin
            od_rdata_nxt = HW_INFO_ENTRIES;
            od_err_nxt = 1'b0;
          end else if (!od_req_i.write && od_req_i.sub == SUB_ONE) begin
            od_rdata_nxt = eeprom_size_i;
            od_err_nxt = 1'b0;
          end
        end
        OBJ_HW_CFG: begin
          if (!od_req_i.write && od_req_i.sub == SUB_ZERO) begin
            od_rdata_nxt = HW_CFG_ENTRIES;
            od_err_nxt = 1'b0;
          end else if (od_req_i.sub == SUB_ONE) begin
            // Stored only; no hardware meaning yet
            if (od_req_i.write) begin
              hw_cfg_nxt = od_req_i.wdata;
            end else begin
              od_rdata_nxt = hw_cfg_r;
            end
            od_err_nxt = 1'b0;
          end
        end
        OBJ_OP_COND: begin
          if (!od_req_i.write && od_req_i.sub == SUB_ZERO) begin
            od_rdata_nxt = OP_COND_ENTRIES;
            od_err_nxt = 1'b0;
          end else if (!od_req_i.write && od_req_i.sub >= SUB_ONE && od_req_i.sub <= OP_COND_ENTRIES[7:0]) begin
            od_rdata_nxt = env_word[3'(od_req_i.sub - SUB_ONE)];
            od_err_nxt = 1'b0;
          end
        end
        default: begin
          od_err_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_code_r <= DEV_CODE_RST;
      lim_code_r <= LIM_CODE_RST;
      hw_cfg_r <= HW_CFG_RST;
      od_ack_r <= 1'b0;
      od_err_r <= 1'b0;
      od_rdata_r <= 32'h00000000;
    end else begin
      dev_code_r <= dev_code_nxt;
      lim_code_r <= lim_code_nxt;
      hw_cfg_r <= hw_cfg_nxt;
      od_ack_r <= od_ack_nxt;
      od_err_r <= od_err_nxt;
      od_rdata_r <= od_rdata_nxt;
    end
  end

  // Event reaction; a deviation error outranks a limit switch in the same cycle
  always_comb begin
    react_valid_nxt = 1'b0;
    react_nxt = react_r;
    warn_nxt = warn_r;
    lim_pos_nxt = lim_pos_r;
    lim_pos_valid_nxt = lim_pos_valid_r;
    if (warn_clear_i) begin
      warn_nxt = 1'b0;
    end
    if (limit_event_i) begin
      warn_nxt = 1'b1;
      if (lim_code_r == CODE_DISCARD) begin
        lim_pos_valid_nxt = 1'b0;
      end else begin
        lim_pos_nxt = limit_pos_i;
        lim_pos_valid_nxt = 1'b1;
      end
      react_nxt = decode_action(lim_code_r, 1'b1);
      react_valid_nxt = 1'b1;
    end
    if (deviation_event_i) begin
      react_nxt = decode_action(dev_code_r, 1'b0);
      react_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      react_valid_r <= 1'b0;
      react_r <= '0;
      warn_r <= 1'b0;
      lim_pos_r <= 32'h00000000;
      lim_pos_valid_r <= 1'b0;
    end else begin
      react_valid_r <= react_valid_nxt;
      react_r <= react_nxt;
      warn_r <= warn_nxt;
      lim_pos_r <= lim_pos_nxt;
      lim_pos_valid_r <= lim_pos_valid_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign od_ack_o = od_ack_r;
  assign od_err_o = od_err_r;
  assign od_rdata_o = od_rdata_r;
  assign react_valid_o = react_valid_r;
  assign react_o = react_r;
  // Warning flag placed at its statusword position; other bits belong elsewhere
  assign drive_status_word_o = 16'(warn_r) << STATUS_WARN_BIT;
  assign limit_pos_o = lim_pos_r;
  assign limit_pos_valid_o = lim_pos_valid_r;

endmodule
`default_nettype wire

//--- hw/frs_pkg.sv
// Constants, object indices and carrier types of the fault reaction selector.
// Assumes a single 25 MHz clock and an object dictionary master on the same clock.
// What this block does
// - Keep a writable signed 16-bit deviation reaction code and apply it on every following or slippage error.
// - Deviation code -1 does nothing, 0 drops the driver, 1 brakes on the mode ramp, 2 on quick stop, 3 up are reserved.
// - A passed limit switch sets statusword warning bit 7 and then runs the limit switch reaction code, unless a deviation error in the same cycle outranks it.
// - Limit code -2 takes no action and throws away the recorded limit switch position.
// - Limit code -1, the reset value, takes no motion action and only records the limit switch position.
// - Limit code 0 drops the driver at once with no ramp and lands in Switch on disabled.
// - Limit code 1 brakes on the mode slow-down ramp and then goes to Switch on disabled.
// - Limit code 2 brakes on the quick-stop ramp and then goes to Switch on disabled.
// - Limit code 5 brakes on the mode slow-down ramp and then goes to Quick stop active.
// - Limit code 6 brakes on the quick-stop ramp and then goes to Quick stop active.
// - After limit codes 5 or 6 the motor stays energized and a return to Operation enabled is allowed.
// - The attached EEPROM size in bytes reads back as a read-only 32-bit value, 0 meaning none fitted.
// - A read-only array of signed 32-bit entries reports the present operating environment values.
`default_nettype none
package frs_pkg;

  // Object indices
  localparam logic [15:0] OBJ_DEV_CODE = 16'h3700;
  localparam logic [15:0] OBJ_LIM_CODE = 16'h3701;
  localparam logic [15:0] OBJ_HW_INFO = 16'h4012;
  localparam logic [15:0] OBJ_HW_CFG = 16'h4013;
  localparam logic [15:0] OBJ_OP_COND = 16'h4014;

  // Entry counts held in subindex 0
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_ONE = 8'h01;
  localparam logic [31:0] HW_INFO_ENTRIES = 32'h00000001;
  localparam logic [31:0] HW_CFG_ENTRIES = 32'h00000001;
  localparam logic [31:0] OP_COND_ENTRIES = 32'h00000005;
  localparam int OP_COND_N = 5;

  // Reset values
  localparam logic [15:0] DEV_CODE_RST = 16'hffff;
  localparam logic [15:0] LIM_CODE_RST = 16'hffff;
  localparam logic [31:0] HW_CFG_RST = 32'h00000000;

  // Reaction codes
  localparam logic [15:0] CODE_DISCARD = 16'hfffe;
  localparam logic [15:0] CODE_NONE = 16'hffff;
  localparam logic [15:0] CODE_OFF = 16'h0000;
  localparam logic [15:0] CODE_SLOW = 16'h0001;
  localparam logic [15:0] CODE_QUICK = 16'h0002;
  localparam logic [15:0] CODE_SLOW_QS = 16'h0005;
  localparam logic [15:0] CODE_QUICK_QS = 16'h0006;

  // Statusword bit set by a passed limit switch
  localparam int STATUS_WARN_BIT = 7;

  // Action handed to the drive state machine
  typedef struct packed {
    logic driver_off;
    logic brake_slow;
    logic brake_quick;
    logic to_switch_on_disabled;
    logic to_quick_stop_active;
    logic keep_energized;
  } frs_action_type;

  // Operating environment values, entries 1 to 5
  typedef struct packed {
    logic [31:0] volt_power_mv;
    logic [31:0] volt_logic_mv;
    logic [31:0] temp_pcb_dc;
    logic [31:0] temp_motor_dc;
    logic [31:0] temp_chip_dc;
  } frs_env_type;

  // Object access request
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } frs_od_req_type;

endpackage
`default_nettype wire

//--- verif/frs_assertions.sv
// Port checker of the fault reaction selector.
// Assumes a bind onto frs_top, one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
module frs_assertions
  import frs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire frs_od_req_type od_req_i,
  input wire logic deviation_event_i,
  input wire logic limit_event_i,
  input wire logic od_ack_o,
  input wire logic od_err_o,
  input wire logic react_valid_o,
  input wire frs_action_type react_o,
  input wire logic [15:0] drive_status_word_o,
  input wire logic limit_pos_valid_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic wrq, bad_dev, ro_wr;
  // Writes that must be refused
  assign wrq = od_req_i.req && od_req_i.write;
  assign bad_dev = wrq && od_req_i.index == OBJ_DEV_CODE &&
    !(od_req_i.wdata[15:0] inside {CODE_NONE, CODE_OFF, CODE_SLOW, CODE_QUICK});
  assign ro_wr = wrq && (od_req_i.index == OBJ_HW_INFO || od_req_i.index == OBJ_OP_COND);
  AST_ACK_NEXT: assert property (od_req_i.req |=> od_ack_o) else $error("late ack");
  AST_DEV_REACT: assert property (deviation_event_i |=> react_valid_o) else $error("no deviation reaction");
  AST_WARN_SET: assert property (limit_event_i |=> drive_status_word_o[STATUS_WARN_BIT])
    else $error("warning bit not set");
  AST_QS_KEEP: assert property (react_o.to_quick_stop_active |-> react_o.keep_energized && !react_o.driver_off)
    else $error("quick stop drops motor");
  AST_SOD_OFF: assert property (react_o.to_switch_on_disabled |-> !react_o.keep_energized)
    else $error("disabled yet energized");
  AST_ONE_RAMP: assert property (react_valid_o |-> $onehot0(react_o[5:3]))
    else $error("two stop actions");
  AST_DEV_REFUSE: assert property (bad_dev |=> od_err_o) else $error("reserved code taken");
  AST_RO_REFUSE: assert property (ro_wr |=> od_ack_o && od_err_o) else $error("read-only written");
  // Main scenarios
  cover property (react_valid_o && react_o.keep_energized);
  cover property (od_ack_o && od_err_o);
  cover property (limit_event_i ##1 !limit_pos_valid_o);
endmodule
bind frs_top frs_assertions u_chk (.*);
`default_nettype wire

//--- verif/frs_master_model.sv
// Object dictionary master model, one request at a time.
// Assumes an answer on the clock after the request is taken.
`timescale 1ns/1ps
`default_nettype none
module frs_master_model
  import frs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic od_ack_i,
  output var frs_od_req_type od_req_o
);
  initial od_req_o = '0;
  // Released fields are inverted so a stale value never looks valid
  task automatic xfer(input frs_od_req_type q, output logic ok);
    ok = 1'b0;
    @(posedge core_clk_i);
    od_req_o <= q;
    @(posedge core_clk_i);
    od_req_o <= ~q;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk_i);
      ok = od_ack_i;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/frs_top_bench.sv
// Self-checking bench: object accesses, reaction codes, events.
// Assumes the master model and the bound checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("BAD %s %h %h", n, e, g); end end
module frs_top_bench
  import frs_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic deviation_event_i = 1'b0;
  logic limit_event_i = 1'b0;
  logic warn_clear_i = 1'b0;
  logic [31:0] limit_pos_i = 32'h0;
  logic [31:0] eeprom_size_i, od_rdata_o, limit_pos_o, pos, lp, rs = 32'h5a;
  frs_env_type env_i;
  frs_od_req_type od_req_i;
  logic od_ack_o, od_err_o, react_valid_o, limit_pos_valid_o, ok, wn = 1'b0, pv = 1'b0;
  frs_action_type react_o;
  logic [15:0] drive_status_word_o;
  logic [33:0] oq[$], oe;
  logic [39:0] rq[$], re;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] lc[7] = '{CODE_NONE, CODE_OFF, CODE_SLOW, CODE_QUICK, CODE_SLOW_QS, CODE_QUICK_QS, CODE_DISCARD};
  frs_top DUT (.*);
  frs_master_model M (.core_clk_i, .od_ack_i(od_ack_o), .od_req_o(od_req_i));
  always #20 core_clk_i = ~core_clk_i;
  // Xorshift source
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Expected action {off, slow, quick, sod, qsa, keep}
  function automatic logic [5:0] act(input logic l, input logic [15:0] c);
    case (c)
      16'h0000: act = l ? 6'h24 : 6'h20;
      16'h0001: act = l ? 6'h14 : 6'h10;
      16'h0002: act = l ? 6'h0c : 6'h08;
      16'h0005: act = 6'h13;
      16'h0006: act = 6'h0b;
      default: act = 6'h00;
    endcase
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic go(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    M.xfer('{1'h1, w, i, s, d}, ok);
    if (!ok) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
    oq.push_back({1'h1, 1'h0, x});
    go(1'h0, i, s, 32'h0);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
    oq.push_back({1'h0, e, 32'h0});
    go(1'h1, i, s, d);
  endtask
  // One event pulse; a discard forgets the position
  task automatic ev(input logic l, input logic [15:0] c);
    pos = rnd();
    if (l) begin
      wn = 1'b1;
      pv = c !== CODE_DISCARD;
      lp = pv ? pos : lp;
    end
    rq.push_back({act(l, c), wn, pv, lp});
    @(posedge core_clk_i);
    limit_event_i <= l;
    deviation_event_i <= !l;
    limit_pos_i <= pos;
    @(posedge core_clk_i);
    limit_event_i <= 1'b0;
    deviation_event_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic code(input logic l, input logic [15:0] c);
    wr(l ? OBJ_LIM_CODE : OBJ_DEV_CODE, SUB_ZERO, {16'h0, c}, 1'h0);
    rd(l ? OBJ_LIM_CODE : OBJ_DEV_CODE, SUB_ZERO, {{16{c[15]}}, c});
    ev(l, c);
  endtask
  // Results are settled by the falling edge
  always @(negedge core_clk_i) begin
    if (od_ack_o === 1'b1) begin
      oe = oq.pop_front();
      `CHK("err", oe[32], od_err_o)
      if (oe[33]) `CHK("rdata", oe[31:0], od_rdata_o)
    end
    if (react_valid_o === 1'b1) begin
      re = rq.pop_front();
      `CHK("react", re[39:34], react_o)
      `CHK("status", {8'h00, re[33], 7'h00}, drive_status_word_o)
      `CHK("pos_valid", re[32], limit_pos_valid_o)
      if (re[32]) `CHK("pos", re[31:0], limit_pos_o)
    end
  end
  initial begin
    env_i = {rnd(), rnd(), rnd(), rnd(), rnd()};
    eeprom_size_i = rnd();
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Reset values and live hardware objects
    rd(OBJ_DEV_CODE, SUB_ZERO, 32'hffffffff);
    rd(OBJ_LIM_CODE, SUB_ZERO, 32'hffffffff);
    rd(OBJ_HW_INFO, SUB_ZERO, HW_INFO_ENTRIES);
    rd(OBJ_HW_INFO, SUB_ONE, eeprom_size_i);
    rd(OBJ_OP_COND, SUB_ZERO, OP_COND_ENTRIES);
    for (int k = 1; k <= OP_COND_N; k++) rd(OBJ_OP_COND, 8'(k), env_i[32*(OP_COND_N-k) +: 32]);
    // Read-only and unmapped targets refuse writes
    wr(OBJ_HW_INFO, SUB_ONE, rnd(), 1'h1);
    wr(OBJ_OP_COND, 8'h03, rnd(), 1'h1);
    wr(OBJ_HW_CFG, SUB_ZERO, 32'h2, 1'h1);
    wr(16'h4015, SUB_ONE, 32'h0, 1'h1);
    pos = rnd();
    wr(OBJ_HW_CFG, SUB_ONE, pos, 1'h0);
    rd(OBJ_HW_CFG, SUB_ONE, pos);
    // Every code; reserved ones leave the last one in force
    for (int j = 0; j < 4; j++) code(1'h0, lc[j]);
    wr(OBJ_DEV_CODE, SUB_ZERO, 32'h7fff, 1'h1);
    ev(1'h0, CODE_QUICK);
    for (int j = 0; j < 7; j++) code(1'h1, lc[j]);
    wr(OBJ_LIM_CODE, SUB_ZERO, 32'h4, 1'h1);
    ev(1'h1, CODE_DISCARD);
    code(1'h1, CODE_NONE);
    // Cleared warning stays clear on a deviation
    warn_clear_i <= 1'b1;
    @(posedge core_clk_i);
    warn_clear_i <= 1'b0;
    wn = 1'b0;
    ev(1'h0, CODE_QUICK);
    repeat (3) @(posedge core_clk_i);
    fails += oq.size() + rq.size();
    end_of_test();
  end
endmodule
`default_nettype wire
